//--- src/ccz_ctl.sv
// Control end: early-decode load flop and zero-detect latch with clear.
`default_nettype none

module ccz_ctl #(
    parameter int unsigned PERIOD_W = ccz_pkg::PERIOD_W
) (
    // Link to the counter chain.
    ccz_link_if.dev                 lnk,
    // Divided output, a copy of the load pulse.
    output logic                    div_out,
    // Prescaler modulus now selected: high for M.
    output logic                    prescale_mod_m,
    // Measured division ratio in input clock cycles.
    output logic [PERIOD_W-1:0]     ratio_cycles,
    // Measured prescaler ticks between loads.
    output logic [PERIOD_W-1:0]     ratio_ticks,
    // High once one full cycle has been measured.
    output logic                    ratio_valid,
    // High while the last cycle was shorter than any legal ratio.
    output logic                    ratio_short
);
    localparam int unsigned DW = ccz_pkg::DIGIT_W;

    // The prescaler must keep the chain below its own ceiling.
    localparam bit RATE_OK =
        ccz_pkg::MCLK_HZ <= ccz_pkg::CHAIN_MAX_HZ;

    // True when the bus node reads high and every decode input reads low.
    function automatic logic flop_data_high(
        input logic          bus_node,
        input logic [DW-1:0] decode_n
    );
        return bus_node && (decode_n == '0);
    endfunction

    // True when the zero-detect latch should set.
    function automatic logic zero_seen(
        input logic          qualifier,
        input logic [DW-1:0] zero_in
    );
        return qualifier && (zero_in == '0);
    endfunction

    // Decode flop and latch state.
    // The load flop is active low like the pin that it drives.
    logic                decode_true;
    logic                decode_load_n;
    logic                clear_pulse;
    logic                zero_latch;

    // Ratio measurement state.
    logic [PERIOD_W-1:0] cyc_cnt;
    logic [PERIOD_W-1:0] tick_cnt;
    logic                seen_load;

    // Capture needs the bus node and the two state together.
    wire logic capture = flop_data_high(lnk.chain_bus_data_input,
                                        lnk.two_state_decode_inputs_n);

    // The decode and clear flops move only on the prescaler edge.
    wire logic edge_en = lnk.presc_tick && RATE_OK;

    // Next state of the decode flop outputs.
    // The load is taken one edge early, so the chain reloads while the
    // lowest stage passes through one and never stalls at zero.
    wire logic next_true = edge_en ? capture : decode_true;
    wire logic next_load = edge_en ? !capture : decode_load_n;

    // The clear path follows the true output by one edge.
    // It is a flop, not a gate, so it cannot glitch the latch.
    wire logic next_clear = edge_en ? decode_true : clear_pulse;

    // A set in the same cycle as a clear wins.
    // Without that, a swallow count of zero would be lost at reload.
    wire logic set_latch = zero_seen(lnk.zero_detect_qualifier,
                                     lnk.zero_detect_inputs);
    wire logic next_latch = set_latch || (zero_latch && !clear_pulse);

    // A new load cycle starts on the edge that pulls the load low.
    wire logic load_start = edge_en && capture &&
                            (decode_load_n == ccz_pkg::LOAD_IDLE);

    // Saturating measurement steps, so a stalled chain reads full scale
    // rather than a wrapped small value.
    wire logic cyc_full = (cyc_cnt == '1);
    wire logic tick_full = (tick_cnt == '1);
    wire logic [PERIOD_W-1:0] next_cyc =
        cyc_full ? cyc_cnt : cyc_cnt + ccz_pkg::PERIOD_ONE;
    wire logic [PERIOD_W-1:0] next_tick =
        tick_full ? tick_cnt : tick_cnt + ccz_pkg::PERIOD_ONE;

    // Legal ratios never give fewer than three ticks a cycle.
    wire logic next_short = next_tick < ccz_pkg::MIN_LOAD_TICKS;

    // Early-decode flop, reset to an idle load.
    always_ff @(posedge lnk.mclk) begin
        if (lnk.sys_rst) begin
            decode_true   <= ccz_pkg::FLAG_CLEAR;
            decode_load_n <= ccz_pkg::LOAD_IDLE;
            clear_pulse   <= ccz_pkg::FLAG_CLEAR;
        end else begin
            decode_true   <= next_true;
            decode_load_n <= next_load;
            clear_pulse   <= next_clear;
        end
    end

    // Zero-detect latch, cleared at reset.
    always_ff @(posedge lnk.mclk) begin
        if (lnk.sys_rst) begin
            zero_latch <= ccz_pkg::FLAG_CLEAR;
        end else begin
            zero_latch <= next_latch;
        end
    end

    // Registered copies for the user side.
    always_ff @(posedge lnk.mclk) begin
        if (lnk.sys_rst) begin
            div_out        <= ccz_pkg::LOAD_IDLE;
            prescale_mod_m <= ccz_pkg::FLAG_CLEAR;
        end else begin
            div_out        <= next_load;
            prescale_mod_m <= next_latch;
        end
    end

    // Input clock cycles between the starts of two loads.
    always_ff @(posedge lnk.mclk) begin
        if (lnk.sys_rst) begin
            cyc_cnt <= ccz_pkg::PERIOD_ONE;
        end else if (load_start) begin
            cyc_cnt <= ccz_pkg::PERIOD_ONE;
        end else begin
            cyc_cnt <= next_cyc;
        end
    end

    // Prescaler ticks between the starts of two loads.
    always_ff @(posedge lnk.mclk) begin
        if (lnk.sys_rst) begin
            tick_cnt <= ccz_pkg::PERIOD_ZERO;
        end else if (load_start) begin
            tick_cnt <= ccz_pkg::PERIOD_ZERO;
        end else if (edge_en) begin
            tick_cnt <= next_tick;
        end
    end

    // The first load after reset only arms the measurement, since the
    // cycle before it was cut short by the reset.
    wire logic                next_valid = seen_load;
    wire logic [PERIOD_W-1:0] next_cycles = seen_load ? cyc_cnt
                                                      : ratio_cycles;
    wire logic [PERIOD_W-1:0] next_ticks = seen_load ? next_tick
                                                     : ratio_ticks;
    wire logic                next_short_flag = seen_load && next_short;

    // Publish a measurement once a full cycle lies between two loads.
    always_ff @(posedge lnk.mclk) begin
        if (lnk.sys_rst) begin
            seen_load    <= ccz_pkg::FLAG_CLEAR;
            ratio_valid  <= ccz_pkg::FLAG_CLEAR;
            ratio_cycles <= ccz_pkg::PERIOD_ZERO;
            ratio_ticks  <= ccz_pkg::PERIOD_ZERO;
            ratio_short  <= ccz_pkg::FLAG_CLEAR;
        end else if (load_start) begin
            seen_load    <= 1'b1;
            ratio_valid  <= next_valid;
            ratio_cycles <= next_cycles;
            ratio_ticks  <= next_ticks;
            ratio_short  <= next_short_flag;
        end
    end

    // Load pulse and divided output, one prescaler period low.
    assign lnk.load_n = decode_load_n;
    assign lnk.decode_flop_true_output = decode_true;
    // The zero output is free for a fast stage reset.
    assign lnk.zero_latch_output = zero_latch;
    assign lnk.latch_clear_output = clear_pulse;

endmodule

`default_nettype wire

//--- inc/ccz_pkg.sv
// Shared constants for the counter reload and zero-detect control pair.
`default_nettype none

package ccz_pkg;

    // Width of one decade counter stage.
    localparam int unsigned DIGIT_W = 4;

    // Documented chain and prescaler defaults.
    localparam int unsigned STAGES_DEF = 8;
    localparam int unsigned PRESC_M_DEF = 10;
    localparam int unsigned PRESC_W = 8;
    localparam int unsigned PERIOD_W = 16;

    // Decade codes.
    localparam logic [DIGIT_W-1:0] DIGIT_ZERO = 4'h0;
    localparam logic [DIGIT_W-1:0] DIGIT_NINE = 4'h9;
    localparam logic [DIGIT_W-1:0] TWO_STATE = 4'h2;

    // Pin levels.
    localparam logic LOAD_IDLE = 1'b1;
    localparam logic LOAD_ACTIVE = 1'b0;
    localparam logic QUAL_ON = 1'b1;
    // Reset level of the decode, clear and latch flags.
    localparam logic FLAG_CLEAR = 1'b0;

    // Clock rates in hertz; the chain must never be ticked faster.
    localparam int unsigned MCLK_HZ = 20_000_000;
    localparam int unsigned CHAIN_MAX_HZ = 25_000_000;

    // Fewest prescaler ticks between loads that a legal ratio gives.
    localparam logic [PERIOD_W-1:0] MIN_LOAD_TICKS = 16'h0003;

    // Measurement counter start and step.
    localparam logic [PERIOD_W-1:0] PERIOD_ONE = 16'h0001;
    localparam logic [PERIOD_W-1:0] PERIOD_ZERO = 16'h0000;

endpackage

`default_nettype wire

//--- inc/ccz_link_if.sv
// Link between the control logic and the counter chain with prescaler.
`default_nettype none

interface ccz_link_if (
    input wire logic mclk,
    input wire logic sys_rst
);
    // Prescaler output edge, one mclk cycle wide.
    logic                            presc_tick;
    // Chain side decode inputs.
    logic                            chain_bus_data_input;
    logic [ccz_pkg::DIGIT_W-1:0]     two_state_decode_inputs_n;
    logic [ccz_pkg::DIGIT_W-1:0]     zero_detect_inputs;
    logic                            zero_detect_qualifier;
    // Control side outputs.
    logic                            load_n;
    logic                            decode_flop_true_output;
    logic                            zero_latch_output;
    logic                            latch_clear_output;

    modport dev (
        input  mclk,
        input  sys_rst,
        input  presc_tick,
        input  chain_bus_data_input,
        input  two_state_decode_inputs_n,
        input  zero_detect_inputs,
        input  zero_detect_qualifier,
        output load_n,
        output decode_flop_true_output,
        output zero_latch_output,
        output latch_clear_output
    );

    modport chain (
        input  mclk,
        input  sys_rst,
        output presc_tick,
        output chain_bus_data_input,
        output two_state_decode_inputs_n,
        output zero_detect_inputs,
        output zero_detect_qualifier,
        input  load_n,
        input  decode_flop_true_output,
        input  zero_latch_output,
        input  latch_clear_output
    );
endinterface

`default_nettype wire

//--- src/ccz_chain.sv
// Counter chain end: two-modulus prescaler, main and swallow counters.
`default_nettype none

module ccz_chain #(
    parameter int unsigned STAGES  = ccz_pkg::STAGES_DEF,
    parameter int unsigned PRESC_M = ccz_pkg::PRESC_M_DEF
) (
    // Link to the control logic.
    ccz_link_if.chain                              lnk,
    // Programmed values, decade coded, least significant stage low.
    input  wire logic [STAGES*ccz_pkg::DIGIT_W-1:0] main_count_value,
    input  wire logic [ccz_pkg::DIGIT_W-1:0]        swallow_count_value,
    // Present state of the chain.
    output logic [STAGES*ccz_pkg::DIGIT_W-1:0]      chain_state,
    output logic                                    presc_tick_out
);
    localparam int unsigned DW = ccz_pkg::DIGIT_W;
    localparam int unsigned CW = STAGES * DW;
    localparam logic [ccz_pkg::PRESC_W-1:0] RELOAD_M =
        ccz_pkg::PRESC_W'(PRESC_M - 1);
    localparam logic [ccz_pkg::PRESC_W-1:0] RELOAD_M1 =
        ccz_pkg::PRESC_W'(PRESC_M);

    // Decade down count of a whole chain, nine after zero in each stage.
    function automatic logic [CW-1:0] chain_dec(input logic [CW-1:0] v);
        logic [CW-1:0] r;
        logic          borrow;
        r = v;
        borrow = 1'b1;
        for (int i = 0; i < STAGES; i++) begin
            if (borrow) begin
                if (v[i*DW +: DW] == ccz_pkg::DIGIT_ZERO) begin
                    r[i*DW +: DW] = ccz_pkg::DIGIT_NINE;
                end else begin
                    r[i*DW +: DW] = v[i*DW +: DW] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        return r;
    endfunction

    logic [CW-1:0]               digits;
    logic [DW-1:0]               swallow;
    logic [ccz_pkg::PRESC_W-1:0] pcnt;
    logic                        tick;

    wire logic [CW-1:0] next_digits = chain_dec(digits);
    wire logic [DW-1:0] next_swallow = (swallow == ccz_pkg::DIGIT_ZERO)
                                       ? ccz_pkg::DIGIT_NINE
                                       : swallow - 4'h1;
    // Modulus is taken only when a prescaler cycle begins.
    wire logic [ccz_pkg::PRESC_W-1:0] next_reload = lnk.zero_latch_output
                                       ? RELOAD_M : RELOAD_M1;
    wire logic load_req = (lnk.load_n == ccz_pkg::LOAD_ACTIVE);

    // Prescaler: M plus one until the zero latch sets, then M.
    always_ff @(posedge lnk.mclk) begin
        if (lnk.sys_rst) begin
            pcnt <= RELOAD_M1;
            tick <= 1'b0;
        end else if (pcnt == '0) begin
            pcnt <= next_reload;
            tick <= 1'b1;
        end else begin
            pcnt <= pcnt - 1'b1;
            tick <= 1'b0;
        end
    end

    // All stages share one load pulse and the tick, no gating.
    always_ff @(posedge lnk.mclk) begin
        if (lnk.sys_rst) begin
            digits  <= main_count_value;
            swallow <= swallow_count_value;
        end else if (tick && load_req) begin
            digits  <= main_count_value;
            swallow <= swallow_count_value;
        end else if (tick) begin
            digits  <= next_digits;
            swallow <= next_swallow;
        end
    end

    always_ff @(posedge lnk.mclk) begin
        chain_state    <= digits;
        presc_tick_out <= tick;
    end

    assign lnk.presc_tick = tick;
    // Lowest stage bus tied low; higher stages form the bus node.
    assign lnk.chain_bus_data_input = (digits[CW-1:DW] == '0);
    // Inputs all low exactly when the lowest stage holds two.
    assign lnk.two_state_decode_inputs_n = digits[DW-1:0] ^
                                           ccz_pkg::TWO_STATE;
    assign lnk.zero_detect_inputs = swallow;
    assign lnk.zero_detect_qualifier = ccz_pkg::QUAL_ON;

endmodule

`default_nettype wire

//--- bench/ccz_link_monitor.sv
// Concurrent checks on the link between the control logic and the chain.
`default_nettype none

module ccz_link_monitor #(
    parameter int unsigned PRESC_M = ccz_pkg::PRESC_M_DEF
) (
    // Clock and reset.
    input wire logic                        mclk,
    input wire logic                        sys_rst,
    // Chain side.
    input wire logic                        presc_tick,
    input wire logic                        chain_bus_data_input,
    input wire logic [ccz_pkg::DIGIT_W-1:0] two_state_decode_inputs_n,
    input wire logic [ccz_pkg::DIGIT_W-1:0] zero_detect_inputs,
    input wire logic                        zero_detect_qualifier,
    // Control side.
    input wire logic                        load_n,
    input wire logic                        decode_flop_true_output,
    input wire logic                        zero_latch_output,
    input wire logic                        latch_clear_output
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] gap_cnt;
    logic        gap_seen;

    // Cycles since the last prescaler tick.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gap_cnt  <= 16'h0000;
            gap_seen <= 1'b0;
        end else if (presc_tick) begin
            gap_cnt  <= 16'h0001;
            gap_seen <= 1'b1;
        end else begin
            gap_cnt <= gap_cnt + 16'h0001;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    property p_load_on_decode;
        presc_tick && chain_bus_data_input &&
            two_state_decode_inputs_n == 4'h0 |=> !load_n;
    endproperty
    a_load_on_decode: assert property (p_load_on_decode)
        else $error("load pulse missing after decode");

    property p_load_release;
        presc_tick && !load_n |=> load_n;
    endproperty
    a_load_release: assert property (p_load_release)
        else $error("load pulse longer than one tick period");

    property p_hold_between_ticks;
        !presc_tick |=> $stable(load_n) && $stable(latch_clear_output);
    endproperty
    a_hold_between_ticks: assert property (p_hold_between_ticks)
        else $error("control output moved without a tick");

    property p_true_inverse;
        decode_flop_true_output != load_n;
    endproperty
    a_true_inverse: assert property (p_true_inverse)
        else $error("true output not inverse of load");

    property p_clear_follows;
        presc_tick && decode_flop_true_output |=> latch_clear_output;
    endproperty
    a_clear_follows: assert property (p_clear_follows)
        else $error("clear did not follow decode");

    property p_clear_cause;
        $rose(latch_clear_output) |->
            $past(decode_flop_true_output) && $past(presc_tick);
    endproperty
    a_clear_cause: assert property (p_clear_cause)
        else $error("clear rose without decode");

    property p_latch_set;
        zero_detect_qualifier && zero_detect_inputs == 4'h0
            |=> zero_latch_output;
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("zero latch failed to set");

    property p_latch_hold;
        zero_latch_output && !latch_clear_output |=> zero_latch_output;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("zero latch dropped without clear");

    property p_latch_clear;
        latch_clear_output && zero_detect_inputs != 4'h0
            |=> !zero_latch_output;
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("zero latch not cleared");

    property p_tick_gap;
        presc_tick && gap_seen |->
            gap_cnt == 16'(PRESC_M) || gap_cnt == 16'(PRESC_M + 1);
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("prescaler period is neither M nor M plus one");
endmodule

`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the control logic facing the counter chain.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [15:0] main;
        logic [3:0]  sw;
        logic [15:0] cyc;
        logic        sel_m;
    } ccz_row_t;

    // Main count, swallow count, the ratio M*main+swallow for M of 10 and
    // the modulus that the zero latch holds as each load starts.
    // Rows keep main at three or more and never below swallow.
    localparam ccz_row_t ROWS [5] = '{
        '{16'h0005, 4'h1, 16'h0033, 1'b1},
        '{16'h0004, 4'h3, 16'h002B, 1'b0},
        '{16'h0003, 4'h0, 16'h001E, 1'b1},
        '{16'h0004, 4'h4, 16'h002C, 1'b0},
        '{16'h0064, 4'h9, 16'h03F1, 1'b1}
    };

    logic        mclk;
    logic        sys_rst;
    logic [31:0] main_val;
    logic [3:0]  sw_val;
    logic        div_out;
    logic        mod_m;
    logic [15:0] ratio_cycles;
    logic [15:0] ratio_ticks;
    logic        ratio_valid;
    logic        ratio_short;
    int          error_cnt;
    int          total_checks;
    int          ticks;

    ccz_link_if lnk (.mclk(mclk), .sys_rst(sys_rst));

    ccz_chain i_ccz_chain (
        .lnk                (lnk),
        .main_count_value   (main_val),
        .swallow_count_value(sw_val),
        .chain_state        (),
        .presc_tick_out     ()
    );

    ccz_ctl i_ccz_ctl (
        .lnk           (lnk),
        .div_out       (div_out),
        .prescale_mod_m(mod_m),
        .ratio_cycles  (ratio_cycles),
        .ratio_ticks   (ratio_ticks),
        .ratio_valid   (ratio_valid),
        .ratio_short   (ratio_short)
    );

    ccz_link_monitor i_ccz_link_monitor (
        .mclk                     (mclk),
        .sys_rst                  (sys_rst),
        .presc_tick               (lnk.presc_tick),
        .chain_bus_data_input     (lnk.chain_bus_data_input),
        .two_state_decode_inputs_n(lnk.two_state_decode_inputs_n),
        .zero_detect_inputs       (lnk.zero_detect_inputs),
        .zero_detect_qualifier    (lnk.zero_detect_qualifier),
        .load_n                   (lnk.load_n),
        .decode_flop_true_output  (lnk.decode_flop_true_output),
        .zero_latch_output        (lnk.zero_latch_output),
        .latch_clear_output       (lnk.latch_clear_output)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    function automatic logic [31:0] bcd(input int v);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; i < 8; i++) begin
            r[i*4 +: 4] = 4'(v % 10);
            v = v / 10;
        end
        return r;
    endfunction

    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Waits for n falling edges of the load pulse, sampled mid-cycle.
    task automatic wait_loads(input int n);
        int   seen;
        logic prev;
        seen = 0;
        prev = lnk.load_n;
        for (int k = 0; k < 15000 && seen < n; k++) begin
            @(negedge mclk);
            if (prev === 1'b1 && lnk.load_n === 1'b0) begin
                seen++;
            end
            prev = lnk.load_n;
        end
        if (seen < n) begin
            error_cnt++;
            close_out();
        end
    endtask

    task automatic check_ratio(input ccz_row_t r);
        check("ratio_cycles", ratio_cycles, r.cyc);
        check("ratio_ticks", ratio_ticks, r.main);
        check("ratio_valid", 16'(ratio_valid), 16'h0001);
        check("ratio_short", 16'(ratio_short), 16'h0000);
        check("prescale_mod_m", 16'(mod_m), 16'(r.sel_m));
    endtask

    task automatic check_idle();
        @(negedge mclk);
        check("load_n", 16'(lnk.load_n), 16'h0001);
        check("div_out", 16'(div_out), 16'h0001);
        check("zero_latch", 16'(lnk.zero_latch_output), 16'h0000);
        check("ratio_valid", 16'(ratio_valid), 16'h0000);
        check("prescale_mod_m", 16'(mod_m), 16'h0000);
    endtask

    initial begin
        error_cnt = 0;
        total_checks = 0;
        sys_rst <= 1'b1;
        main_val <= bcd(int'(ROWS[0].main));
        sw_val <= ROWS[0].sw;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        check_idle();
        foreach (ROWS[i]) begin
            @(posedge mclk);
            main_val <= bcd(int'(ROWS[i].main));
            sw_val <= ROWS[i].sw;
            wait_loads(3);
            check_ratio(ROWS[i]);
        end
        // The load pulse must end at the first tick after it starts.
        wait_loads(1);
        ticks = 0;
        check("true_out", 16'(lnk.decode_flop_true_output), 16'h0001);
        for (int k = 0; k < 40 && lnk.load_n === 1'b0; k++) begin
            ticks += int'(lnk.presc_tick);
            @(negedge mclk);
        end
        check("ticks_in_load", 16'(ticks), 16'h0001);
        check("load_n", 16'(lnk.load_n), 16'h0001);
        // Reset in mid-run, then the last setting must measure again.
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        check_idle();
        wait_loads(3);
        check_ratio(ROWS[4]);
        // A forbidden main count of two must raise the short flag.
        @(posedge mclk);
        main_val <= bcd(2);
        sw_val <= 4'h0;
        wait_loads(3);
        check("short_ticks", ratio_ticks, 16'h0002);
        check("short_cycles", ratio_cycles, 16'h0014);
        check("short_flag", 16'(ratio_short), 16'h0001);
        close_out();
    end
endmodule

`default_nettype wire
